// >>> bench/cocu_host.sv
// host adapter model driving the command port
`timescale 1ns/10ps
module cocu_host (
    input  logic        clock,
    input  logic [7:0]  status,
    input  logic [15:0] data_out,
    output logic        cmd_we,
    output logic [7:0]  cmd_code,
    output logic [7:0]  cmd_feature,
    output logic        data_rd,
    output logic        data_wr,
    output logic [15:0] data_in
);
    // ********************
    // host transfers
    // ********************
    logic [15:0] words [0:255];
    logic [15:0] wbuf  [0:255];
    int          slow = 0;
    initial begin
        cmd_we = 1'b0;
        cmd_code = 8'h00;
        cmd_feature = 8'h00;
        data_rd = 1'b0;
        data_wr = 1'b0;
        data_in = 16'h0000;
    end
    task issue(input logic [7:0] code, input logic [7:0] feat);
        @(posedge clock);
        cmd_we <= 1'b1;
        cmd_code <= code;
        cmd_feature <= feat;
        @(posedge clock);
        cmd_we <= 1'b0;
        cmd_code <= ~code;
        cmd_feature <= ~feat;
    endtask
    task automatic drq_wait(output bit ok);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (status[3] !== 1'b1 && n < 20);
        ok = status[3] === 1'b1;
    endtask
    // one pulse per word; random gaps model a slow host
    task read_all();
        for (int i = 0; i < 256; i++) begin
            words[i] = data_out;
            data_rd <= 1'b1;
            @(posedge clock);
            data_rd <= 1'b0;
            repeat ($urandom_range(slow)) @(posedge clock);
            @(posedge clock);
        end
    endtask
    // released data lines show the inverse, not the last word
    task send_all();
        for (int i = 0; i < 256; i++) begin
            data_in <= wbuf[i];
            data_wr <= 1'b1;
            @(posedge clock);
            data_wr <= 1'b0;
            data_in <= ~wbuf[i];
            repeat ($urandom_range(slow)) @(posedge clock);
            @(posedge clock);
        end
    endtask
endmodule

// >>> bench/cocu_top_sva.sv
// port assertions of the overlay command unit
`timescale 1ns/10ps
`include "cocu_defines.vh"
module cocu_top_sva (
    input logic        clock,
    input logic        rst,
    input logic        pwr_rst,
    input logic        clk_en,
    input logic        cmd_we,
    input logic [7:0]  cmd_code,
    input logic [7:0]  cmd_feature,
    input logic [7:0]  command_status_flags,
    input logic [7:0]  command_error_flags,
    input logic [7:0]  sector_count_out,
    input logic [7:0]  cylinder_low_out,
    input logic [7:0]  cylinder_high_out,
    input logic        cmd_done,
    input logic [15:0] cap_word63,
    input logic [15:0] cap_word88,
    input logic [47:0] max_lba_out
);
    // ********************
    // command port checks
    // ********************
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst || pwr_rst);
    // only an idle unit takes a command
    wire take = clk_en && cmd_we && cmd_code == `COCU_OPCODE
        && !command_status_flags[7] && !command_status_flags[3];
    wire dat = cmd_feature == `COCU_FEAT_IDENTIFY || cmd_feature == `COCU_FEAT_SET;

    a_busy_then_done: assert property (take && !dat |=> command_status_flags[7]
        ##1 (cmd_done && !command_status_flags[7])) else $error("short command timing");
    a_busy_take: assert property (take |=> command_status_flags[7])
        else $error("busy missing after command");
    a_error_mask: assert property ((command_error_flags & 8'hfb) == 8'h00)
        else $error("error bit other than abort");
    a_abort_status: assert property (cmd_done && command_error_flags[2]
        |-> command_status_flags[0] && $stable(cap_word63) && $stable(max_lba_out))
        else $error("abort status or overlay wrong");
    a_protect_codes: assert property (cmd_done && sector_count_out == 8'h06
        |-> cylinder_high_out == 8'h03 && cylinder_low_out == 8'h00)
        else $error("protected area codes wrong");
    a_caps_subset: assert property ((cap_word63 & ~`COCU_FULL_MWDMA) == 16'h0000
        && (cap_word88 & ~`COCU_FULL_UDMA) == 16'h0000) else $error("capability beyond full");
    a_caps_quiet: assert property ($changed(cap_word63) || $changed(max_lba_out)
        |-> cmd_done) else $error("overlay changed outside completion");
    a_done_idle: assert property (cmd_done |-> !command_status_flags[7]
        && !command_status_flags[3] && max_lba_out <= `COCU_FULL_LBA)
        else $error("completion not idle");
endmodule

bind cocu_top cocu_top_sva cocu_top_sva_i (.clock(clock), .rst(rst), .pwr_rst(pwr_rst),
    .clk_en(clk_en), .cmd_we(cmd_we), .cmd_code(cmd_code), .cmd_feature(cmd_feature),
    .command_status_flags(command_status_flags), .command_error_flags(command_error_flags),
    .sector_count_out(sector_count_out), .cylinder_low_out(cylinder_low_out),
    .cylinder_high_out(cylinder_high_out), .cmd_done(cmd_done), .cap_word63(cap_word63),
    .cap_word88(cap_word88), .max_lba_out(max_lba_out));

// >>> bench/cocu_top_tb.sv
// self-checking bench of the overlay command unit
`timescale 1ns/10ps
`include "cocu_defines.vh"
module cocu_top_tb;
    // ********************
    // bench and scenarios
    // ********************
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        pwr_rst = 1'b1;
    logic        hpa = 1'b0;
    wire         we, rd, wr, done;
    wire  [7:0]  code, feat, status, err, sc, cl, ch;
    wire  [15:0] din, dout, c63, c82, c83, c84, c88;
    wire  [47:0] lba_o;
    logic [47:0] q [$];
    logic [47:0] lba;
    logic [15:0] mw;
    logic [7:0]  s;
    int          mismatches = 0;
    int          checked = 0;
    logic [7:0]  rsv [4] = '{8'hc4, 8'h00, 8'hbf, 8'hff};
    localparam logic [47:0] res_ok = 48'h0000_0000_0040;
    always #2 clock = ~clock;
    cocu_top cocu_top_i (.clock(clock), .rst(rst), .pwr_rst(pwr_rst), .clk_en(1'b1),
        .cmd_we(we), .cmd_code(code), .cmd_feature(feat), .data_rd(rd), .data_wr(wr),
        .data_in(din), .hpa_established(hpa), .data_out(dout), .command_status_flags(status),
        .command_error_flags(err), .sector_count_out(sc), .cylinder_low_out(cl),
        .cylinder_high_out(ch), .cmd_done(done), .cap_word63(c63), .cap_word82(c82),
        .cap_word83(c83), .cap_word84(c84), .cap_word88(c88), .max_lba_out(lba_o));
    cocu_host host_i (.clock(clock), .status(status), .data_out(dout), .cmd_we(we),
        .cmd_code(code), .cmd_feature(feat), .data_rd(rd), .data_wr(wr), .data_in(din));
    function automatic logic [47:0] ab(input logic [7:0] r, input logic [7:0] w);
        return {8'h00, 8'h04, r, 8'h00, w, 8'h41};
    endfunction
    task check(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task print_verdict();
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // results are taken off the queue as completions appear
    always @(posedge clock) begin
        if (done === 1'b1) begin
            check({8'h00, err, sc, cl, ch, status}, q.size() ? q.pop_front() : 48'hx);
        end
    end
    task automatic run(input logic [7:0] f, input bit xfer, input logic [47:0] exp);
        int n;
        bit ok;
        n = 0;
        q.push_back(exp);
        host_i.issue(`COCU_OPCODE, f);
        if (xfer) begin
            host_i.drq_wait(ok);
            check(48'(ok), 48'h1);
            if (f == `COCU_FEAT_IDENTIFY) host_i.read_all();
            else host_i.send_all();
        end
        while (q.size() != 0 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        if (q.size() != 0) begin
            mismatches++;
            print_verdict();
        end
    endtask
    // integrity word makes all bytes sum to zero
    task fill(input logic [15:0] m, input logic [47:0] l);
        for (int i = 0; i < 256; i++) host_i.wbuf[i] = 16'h0000;
        host_i.wbuf[0] = `COCU_DS_REVISION;
        host_i.wbuf[1] = m;
        host_i.wbuf[2] = `COCU_FULL_UDMA | 16'h0080;
        {host_i.wbuf[5], host_i.wbuf[4], host_i.wbuf[3]} = l;
        host_i.wbuf[7] = `COCU_FULL_SETS;
        host_i.wbuf[8] = `COCU_FULL_SETS2;
        host_i.wbuf[21] = `COCU_FULL_SETS3;
        s = `COCU_SIGNATURE;
        for (int i = 0; i < 255; i++) s = s + host_i.wbuf[i][7:0] + host_i.wbuf[i][15:8];
        host_i.wbuf[255] = {8'h00 - s, `COCU_SIGNATURE};
    endtask
    initial begin
        void'($urandom(94698));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        pwr_rst <= 1'b0;
        @(posedge clock);
        check(48'({err, status}), 48'h0040);
        host_i.slow = 2;
        run(`COCU_FEAT_IDENTIFY, 1'b1, res_ok);
        s = 8'h00;
        for (int i = 0; i < 256; i++) s = s + host_i.words[i][7:0] + host_i.words[i][15:8];
        check(48'(host_i.words[0]), 48'(`COCU_DS_REVISION));
        check(48'(host_i.words[255][7:0]), 48'(`COCU_SIGNATURE));
        check(48'(s), 48'h0);
        mw = 16'($urandom_range(6));
        lba = `COCU_FULL_LBA - 48'($urandom_range(255)) - 48'h1;
        fill(mw, lba);
        host_i.slow = 0;
        run(`COCU_FEAT_SET, 1'b1, res_ok);
        check(48'(c63), 48'(mw));
        check(48'(c88), 48'(`COCU_FULL_UDMA));
        check(lba_o, lba);
        check({c82, c83, c84}, {`COCU_FULL_SETS, `COCU_FULL_SETS2, `COCU_FULL_SETS3});
        run(`COCU_FEAT_IDENTIFY, 1'b1, res_ok);
        check(48'(host_i.words[1]), 48'(`COCU_FULL_MWDMA));
        fill(16'h0000, lba);
        host_i.wbuf[9] = 16'h0001;
        run(`COCU_FEAT_SET, 1'b1, ab(8'h01, 8'hff));
        check(48'(c63), 48'(mw));
        hpa <= 1'b1;
        run(`COCU_FEAT_RESTORE, 1'b0, ab(8'h06, 8'h03));
        fill(mw, `COCU_FULL_LBA);
        run(`COCU_FEAT_SET, 1'b1, ab(8'h06, 8'h03));
        hpa <= 1'b0;
        run(`COCU_FEAT_RESTORE, 1'b0, res_ok);
        check({c63, lba_o[31:0]}, {`COCU_FULL_MWDMA, 32'(`COCU_FULL_LBA)});
        host_i.issue(8'hec, `COCU_FEAT_RESTORE);
        repeat (4) @(posedge clock);
        check(48'(status), 48'h40);
        foreach (rsv[i]) run(rsv[i], 1'b0, ab(8'h00, 8'h00));
        run(`COCU_FEAT_FREEZE, 1'b0, res_ok);
        // frozen unit must refuse every subcommand, data ones included
        for (int f = 8'hc0; f <= 8'hc3; f++) run(8'(f), 1'b0, ab(8'h00, 8'h00));
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        run(`COCU_FEAT_RESTORE, 1'b0, ab(8'h00, 8'h00));
        rst <= 1'b1;
        pwr_rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        pwr_rst <= 1'b0;
        run(`COCU_FEAT_RESTORE, 1'b0, res_ok);
        print_verdict();
    end
endmodule

// >>> logic/cocu_bsum.v
// unsigned byte-sum accumulator step, overflow dropped
`timescale 1ns/10ps
module cocu_bsum (
    input  wire [7:0]  acc,
    input  wire [15:0] word,
    output wire [7:0]  sum
);
    wire [9:0] wide;

    // ****************************************
    // add both bytes of the word
    // ****************************************
    // modulo-256 byte sum
    assign wide = {2'b00, acc} + {2'b00, word[7:0]} + {2'b00, word[15:8]};
    assign sum  = wide[7:0];
endmodule

// >>> logic/cocu_top.v
// configuration-overlay command handler behind the command-block registers
`timescale 1ns/10ps
`include "cocu_defines.vh"
module cocu_top (
    input  wire        clock,
    input  wire        rst,
    input  wire        pwr_rst,
    input  wire        clk_en,
    input  wire        cmd_we,
    input  wire [7:0]  cmd_code,
    input  wire [7:0]  cmd_feature,
    input  wire        data_rd,
    input  wire        data_wr,
    input  wire [15:0] data_in,
    input  wire        hpa_established,
    output wire [15:0] data_out,
    output reg  [7:0]  command_status_flags,
    output wire [7:0]  command_error_flags,
    output wire [7:0]  sector_count_out,
    output wire [7:0]  cylinder_low_out,
    output wire [7:0]  cylinder_high_out,
    output wire        cmd_done,
    output wire [15:0] cap_word63,
    output wire [15:0] cap_word82,
    output wire [15:0] cap_word83,
    output wire [15:0] cap_word84,
    output wire [15:0] cap_word88,
    output wire [47:0] max_lba_out
);
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_EXEC  = 3'd1;
    localparam [2:0] ST_DIN   = 3'd2;
    localparam [2:0] ST_DOUT  = 3'd3;
    localparam [2:0] ST_CHECK = 3'd4;

    reg  [2:0]  state;
    reg  [7:0]  feat;
    reg  [7:0]  idx;
    reg  [7:0]  acc;
    reg  [15:0] tx_word;
    reg  [7:0]  err_reg;
    reg  [7:0]  sc_reg;
    reg  [7:0]  cl_reg;
    reg  [7:0]  ch_reg;
    reg         done_reg;
    reg  [15:0] rx_mwdma;
    reg  [15:0] rx_udma;
    reg  [15:0] rx_sets;
    reg  [15:0] rx_sets2;
    reg  [15:0] rx_sets3;
    reg  [47:0] rx_lba;
    reg  [7:0]  rx_sig;
    reg         frozen;
    reg  [15:0] cur_mwdma;
    reg  [15:0] cur_udma;
    reg  [15:0] cur_sets;
    reg  [15:0] cur_sets2;
    reg  [15:0] cur_sets3;
    reg  [47:0] cur_lba;
    reg         fin;
    reg         fail;
    reg  [7:0]  f_rsn;
    reg  [7:0]  f_word;
    wire        cmd_ours;
    wire        in_din;
    wire [7:0]  tx_idx;
    wire [15:0] sum_word;
    wire [7:0]  nsum;
    wire [15:0] lut_word;
    wire        lba_lock;
    wire        sum_ok;
    wire        lba_over;
    wire        lba_chg;
    wire        in_exec;
    wire        do_restore;
    wire        do_freeze;
    wire        do_set;
    wire        command_aborted_flag;
    wire        transfer_request_flag;

    // ****************************************
    // command decode
    // ****************************************
    // only the family opcode, only when idle
    assign cmd_ours = cmd_we && (cmd_code == `COCU_OPCODE) && (state == ST_IDLE);
    assign in_din   = (state == ST_DIN);
    assign tx_idx   = in_din ? (idx + 8'h01) : 8'h00;
    assign sum_word = in_din ? tx_word : data_in;

    cocu_bsum u_bsum (
        .acc  (acc),
        .word (sum_word),
        .sum  (nsum)
    );

    cocu_word u_word (
        .idx    (tx_idx),
        .sum_in (nsum),
        .word   (lut_word)
    );

    // ****************************************
    // checks on a received overlay
    // ****************************************
    // protected area pins the max lba
    assign lba_lock = hpa_established && (cur_lba != `COCU_FULL_LBA);
    // received bytes must sum to zero
    assign sum_ok   = (acc == 8'h00) && (rx_sig == `COCU_SIGNATURE);
    assign lba_over = (rx_lba > `COCU_FULL_LBA);
    // with a protected area, set may not move the max lba
    assign lba_chg  = hpa_established && (rx_lba != cur_lba);

    // ****************************************
    // completion decision
    // ****************************************
    always @* begin
        fin    = 1'b0;
        fail   = 1'b0;
        f_rsn  = `COCU_RSN_NONE;
        f_word = `COCU_WORD_NONE;
        case (state)
            ST_EXEC: begin
                if (frozen) begin
                    fin  = 1'b1;
                    fail = 1'b1;
                end else begin
                    case (feat)
                        `COCU_FEAT_RESTORE: begin
                            fin = 1'b1;
                            // restore may not move it either
                            if (lba_lock) begin
                                fail   = 1'b1;
                                f_rsn  = `COCU_RSN_PROTECTED;
                                f_word = `COCU_WORD_LBA;
                            end
                        end
                        `COCU_FEAT_FREEZE: fin = 1'b1;
                        `COCU_FEAT_IDENTIFY: fin = 1'b0;
                        `COCU_FEAT_SET: fin = 1'b0;
                        default: begin
                            fin  = 1'b1;
                            fail = 1'b1;
                        end
                    endcase
                end
            end
            ST_DIN: begin
                fin = data_rd && (idx == `COCU_LAST_WORD);
            end
            ST_CHECK: begin
                fin = 1'b1;
                if (!sum_ok) begin
                    fail   = 1'b1;
                    f_rsn  = `COCU_RSN_CHECKSUM;
                    f_word = `COCU_WORD_INTEG;
                end else if (lba_over) begin
                    fail   = 1'b1;
                    f_rsn  = `COCU_RSN_LBA_RANGE;
                    f_word = `COCU_WORD_LBA;
                end else if (lba_chg) begin
                    fail   = 1'b1;
                    f_rsn  = `COCU_RSN_PROTECTED;
                    f_word = `COCU_WORD_LBA;
                end
            end
            default: fin = 1'b0;
        endcase
    end

    assign in_exec    = (state == ST_EXEC) && !frozen;
    // aborted requests leave the overlay alone
    assign do_restore = in_exec && (feat == `COCU_FEAT_RESTORE) && !lba_lock;
    assign do_freeze  = in_exec && (feat == `COCU_FEAT_FREEZE);
    assign do_set     = (state == ST_CHECK) && !fail;

    // ****************************************
    // command sequencer
    // ****************************************
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state    <= ST_IDLE;
            feat     <= 8'h00;
            idx      <= 8'h00;
            acc      <= 8'h00;
            tx_word  <= 16'h0000;
            err_reg  <= 8'h00;
            sc_reg   <= 8'h00;
            cl_reg   <= 8'h00;
            ch_reg   <= 8'h00;
            done_reg <= 1'b0;
            rx_mwdma <= 16'h0000;
            rx_udma  <= 16'h0000;
            rx_sets  <= 16'h0000;
            rx_sets2 <= 16'h0000;
            rx_sets3 <= 16'h0000;
            rx_lba   <= 48'h0000_0000_0000;
            rx_sig   <= 8'h00;
        end else if (clk_en) begin
            done_reg <= 1'b0;
            if (cmd_ours) begin
                state   <= ST_EXEC;
                feat    <= cmd_feature;
                err_reg <= 8'h00;
                sc_reg  <= 8'h00;
                cl_reg  <= 8'h00;
                ch_reg  <= 8'h00;
            end else if (fin) begin
                // abort ends busy with the error flag
                state    <= ST_IDLE;
                done_reg <= 1'b1;
                // abort flag is the only error bit
                err_reg  <= fail ? (8'h01 << `COCU_ERR_ABT) : 8'h00;
                sc_reg   <= f_rsn;
                ch_reg   <= f_word;
                cl_reg   <= 8'h00;
            end else begin
                case (state)
                    ST_EXEC: begin
                        idx <= 8'h00;
                        acc <= 8'h00;
                        if (feat == `COCU_FEAT_IDENTIFY) begin
                            state   <= ST_DIN;
                            tx_word <= lut_word;
                        end else begin
                            state <= ST_DOUT;
                        end
                    end
                    ST_DIN: begin
                        // running sum feeds the last word
                        if (data_rd) begin
                            acc     <= nsum;
                            idx     <= tx_idx;
                            tx_word <= lut_word;
                        end
                    end
                    ST_DOUT: begin
                        if (data_wr) begin
                            acc <= nsum;
                            idx <= idx + 8'h01;
                            case (idx)
                                `COCU_W_MWDMA:   rx_mwdma <= data_in;
                                `COCU_W_UDMA:    rx_udma <= data_in;
                                `COCU_W_LBA0:    rx_lba[15:0] <= data_in;
                                `COCU_W_LBA1:    rx_lba[31:16] <= data_in;
                                `COCU_W_LBA2:    rx_lba[47:32] <= data_in;
                                `COCU_W_SETS:    rx_sets <= data_in;
                                `COCU_W_SETS2:   rx_sets2 <= data_in;
                                `COCU_W_SETS3:   rx_sets3 <= data_in;
                                `COCU_LAST_WORD: rx_sig <= data_in[7:0];
                                default:         rx_sig <= rx_sig;
                            endcase
                            if (idx == `COCU_LAST_WORD) begin
                                state <= ST_CHECK;
                            end
                        end
                    end
                    default: state <= state;
                endcase
            end
        end
    end

    // ****************************************
    // overlay state, power-down only
    // ****************************************
    // bus resets cannot unfreeze
    always @(posedge clock or posedge pwr_rst) begin
        if (pwr_rst) begin
            frozen    <= 1'b0;
            cur_mwdma <= `COCU_FULL_MWDMA;
            cur_udma  <= `COCU_FULL_UDMA;
            cur_sets  <= `COCU_FULL_SETS;
            cur_sets2 <= `COCU_FULL_SETS2;
            cur_sets3 <= `COCU_FULL_SETS3;
            cur_lba   <= `COCU_FULL_LBA;
        end else if (clk_en) begin
            if (do_freeze) begin
                frozen <= 1'b1;
            end
            if (do_restore) begin
                cur_mwdma <= `COCU_FULL_MWDMA;
                cur_udma  <= `COCU_FULL_UDMA;
                cur_sets  <= `COCU_FULL_SETS;
                cur_sets2 <= `COCU_FULL_SETS2;
                cur_sets3 <= `COCU_FULL_SETS3;
                cur_lba   <= `COCU_FULL_LBA;
            end
            // masking by the full set ignores extra ones
            if (do_set) begin
                cur_mwdma <= rx_mwdma & `COCU_FULL_MWDMA;
                cur_udma  <= rx_udma & `COCU_FULL_UDMA;
                cur_sets  <= rx_sets & `COCU_FULL_SETS;
                cur_sets2 <= rx_sets2 & `COCU_FULL_SETS2;
                cur_sets3 <= rx_sets3 & `COCU_FULL_SETS3;
                cur_lba   <= rx_lba;
            end
        end
    end

    // ****************************************
    // status and result registers
    // ****************************************
    assign command_aborted_flag  = err_reg[`COCU_ERR_ABT];
    assign transfer_request_flag = in_din || (state == ST_DOUT);

    always @* begin
        command_status_flags = 8'h00;
        command_status_flags[`COCU_STAT_BSY] = (state == ST_EXEC) || (state == ST_CHECK);
        command_status_flags[`COCU_STAT_RDY] = 1'b1;
        command_status_flags[`COCU_STAT_DRQ] = transfer_request_flag;
        command_status_flags[`COCU_STAT_ERR] = command_aborted_flag;
    end

    assign command_error_flags = err_reg;
    assign sector_count_out    = sc_reg;
    assign cylinder_low_out    = cl_reg;
    assign cylinder_high_out   = ch_reg;
    assign cmd_done            = done_reg;
    assign data_out            = tx_word;

    // ****************************************
    // reduced words seen by identify device
    // ****************************************
    // only these five words and the max lba can shrink
    assign cap_word63  = cur_mwdma;
    assign cap_word88  = cur_udma;
    assign cap_word82  = cur_sets;
    assign cap_word83  = cur_sets2;
    assign cap_word84  = cur_sets3;
    assign max_lba_out = cur_lba;
endmodule

// >>> logic/cocu_word.v
// word lookup of the identify overlay structure
`timescale 1ns/10ps
`include "cocu_defines.vh"
module cocu_word (
    input  wire [7:0]  idx,
    input  wire [7:0]  sum_in,
    output reg  [15:0] word
);
    wire [7:0]  sig_sum;
    wire [7:0]  chk;
    wire [47:0] full_lba;

    // lba split into its three words on purpose
    assign full_lba = `COCU_FULL_LBA;

    // ****************************************
    // integrity byte
    // ****************************************
    // two's complement of the sum
    assign sig_sum = sum_in + `COCU_SIGNATURE;
    assign chk     = ~sig_sum + 8'h01;

    // ****************************************
    // structure content
    // ****************************************
    // always the full selectable set
    always @* begin
        case (idx)
            8'h00:           word = `COCU_DS_REVISION;
            `COCU_W_MWDMA:   word = `COCU_FULL_MWDMA;
            `COCU_W_UDMA:    word = `COCU_FULL_UDMA;
            `COCU_W_LBA0:    word = full_lba[15:0];
            `COCU_W_LBA1:    word = full_lba[31:16];
            `COCU_W_LBA2:    word = full_lba[47:32];
            `COCU_W_SETS:    word = `COCU_FULL_SETS;
            `COCU_W_SETS2:   word = `COCU_FULL_SETS2;
            `COCU_W_SETS3:   word = `COCU_FULL_SETS3;
            `COCU_LAST_WORD: word = {chk, `COCU_SIGNATURE};
            default:         word = 16'h0000;
        endcase
    end
endmodule

// >>> shared/cocu_defines.vh
// constants of the configuration-overlay command unit
// What this block does
// - opcode b1h written to the command port starts this command family.
// - feature c0h restore, c1h freeze lock, c2h identify, c3h set; others rejected.
// - restore undoes every earlier reduction and brings back the full capabilities; with a protected area and a reduced max lba it is aborted instead.
// - after a freeze lock every later subcommand of the family is aborted.
// - the freeze lock survives hardware and software reset; only power-down clears it.
// - identify returns one 512-byte structure as a pio data-in transfer.
// - identify always shows the full set while the reported words show the reduced set.
// - set changes only the capability bits behind reported words 63, 82, 83, 84 and 88, and the max lba.
// - a capability bit cleared by set withdraws that capability.
// - a received bit that is one where the full set holds zero changes nothing.
// - a violated restriction aborts with reason and word in the result registers; the bit register stays 00h.
// - only the abort flag at bit 2 of the error register may ever be set.
// - with a protected area, a max lba change is aborted with word 03h, reason 06h.
// - the low byte of the last structure word is the signature a5h.
// - the high byte of the last word makes all structure bytes sum to zero.
`ifndef COCU_DEFINES_VH
`define COCU_DEFINES_VH

// ****************************************
// command codes
// ****************************************
`define COCU_OPCODE        8'hb1
`define COCU_FEAT_RESTORE  8'hc0
`define COCU_FEAT_FREEZE   8'hc1
`define COCU_FEAT_IDENTIFY 8'hc2
`define COCU_FEAT_SET      8'hc3

// ****************************************
// status and error bit positions
// ****************************************
`define COCU_STAT_BSY      7
`define COCU_STAT_RDY      6
`define COCU_STAT_DRQ      3
`define COCU_STAT_ERR      0
`define COCU_ERR_ABT       2

// ****************************************
// structure layout
// ****************************************
`define COCU_LAST_WORD     8'hff
`define COCU_SIGNATURE     8'ha5
`define COCU_DS_REVISION   16'h0002
`define COCU_W_MWDMA       8'h01
`define COCU_W_UDMA        8'h02
`define COCU_W_LBA0        8'h03
`define COCU_W_LBA1        8'h04
`define COCU_W_LBA2        8'h05
`define COCU_W_SETS        8'h07
`define COCU_W_SETS2       8'h08
`define COCU_W_SETS3       8'h15

// ****************************************
// reason and word codes of an abort
// ****************************************
`define COCU_RSN_NONE      8'h00
`define COCU_RSN_CHECKSUM  8'h01
`define COCU_RSN_LBA_RANGE 8'h02
`define COCU_RSN_PROTECTED 8'h06
`define COCU_WORD_NONE     8'h00
`define COCU_WORD_LBA      8'h03
`define COCU_WORD_INTEG    8'hff

// ****************************************
// full capability set (power-up values)
// ****************************************
`define COCU_FULL_MWDMA    16'h0007
`define COCU_FULL_UDMA     16'h007f
`define COCU_FULL_SETS     16'h03bf
`define COCU_FULL_SETS2    16'h0017
`define COCU_FULL_SETS3    16'h2200
`define COCU_FULL_LBA      48'h0000_0100_0000

`endif
